//--- hw/iorsd_decoder.sv
`timescale 1ns/1ps
// Overview of operation
// R1: Bit set/clear only on I/O 0x00..0x1F.
// R2: Skip tests read one bit there.
// R3: Writing one clears status flag; zero keeps. Serial flags here ignore core writes and clear only at reset.
// R4: Bit operations touch only the target bit.
// R5: Core uses I/O addresses 0x00..0x3F.
// R6: Data address is I/O address plus 0x20.
// R7: I/O instructions reach exactly 64 locations.
// R8: Extended 0x60..0xFF only by load/store.
// R9: Reserved locations read zero, ignore writes.
module iorsd_decoder
  import iorsd_pkg::*;
(
  input wire logic core_clk, // System clock.
  input wire logic rst_b, // Synchronous reset, active low.
  input wire iorsd_req_type req, // Access from the core, one per cycle.
  output iorsd_rsp_type rsp, // Read data, skip result, decode hit.
  output logic ext_sel, // Access aimed at the extended space.
  input wire logic [7:0] ext_rdata, // Read data from the extended space.
  input wire iorsd_flags_type flag_set, // Flag set pulses from peripherals.
  output iorsd_flags_type flag_q, // Current status flags.
  input wire logic [7:0] port_b_pins, // Raw port B pin levels.
  input wire logic [7:0] port_c_pins, // Raw port C pin levels.
  input wire logic [7:0] port_d_pins, // Raw port D pin levels.
  output logic [7:0] port_b_dir, // Port B direction.
  output logic [7:0] port_b_out, // Port B output latch.
  output logic [7:0] port_c_dir, // Port C direction.
  output logic [7:0] port_c_out, // Port C output latch.
  output logic [7:0] port_d_dir, // Port D direction.
  output logic [7:0] port_d_out // Port D output latch.
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic io_acc;
  logic data_acc;
  logic bit_acc;
  logic wr_acc;
  logic rd_acc;
  logic [5:0] loc;
  logic [7:0] bit_mask;
  logic [7:0] cur;
  logic [7:0] wval;
  logic [7:0] w1c;

  function automatic logic [7:0] onehot(input logic [2:0] b);
    onehot = 8'h01 << b;
  endfunction

  // Data accesses fold onto the six-bit I/O location so that one read mux serves both paths.
  always_comb begin
    io_acc = 1'b0;
    data_acc = 1'b0;
    bit_acc = 1'b0;
    loc = req.addr[5:0]; // R7
    case (iorsd_op_type'(req.op))
      IORSD_OP_IO_READ, IORSD_OP_IO_WRITE: begin
        io_acc = (req.addr <= IO_LAST); // R5
      end
      IORSD_OP_DATA_READ, IORSD_OP_DATA_WRITE: begin
        data_acc = (req.addr >= IO_DATA_OFFSET) && (req.addr < EXT_FIRST); // R6
        loc = 6'(req.addr - IO_DATA_OFFSET); // R6
      end
      IORSD_OP_SET_BIT, IORSD_OP_CLEAR_BIT, IORSD_OP_SKIP_IF_ONE, IORSD_OP_SKIP_IF_ZERO: begin
        bit_acc = (req.addr <= IO_BIT_LAST); // R1
      end
      default: begin
      end
    endcase
  end

  assign wr_acc = (io_acc && iorsd_op_type'(req.op) == IORSD_OP_IO_WRITE)
                  || (data_acc && iorsd_op_type'(req.op) == IORSD_OP_DATA_WRITE);
  assign rd_acc = io_acc || data_acc || bit_acc;
  // Extended space never answers to I/O or bit instructions.
  assign ext_sel = (iorsd_op_type'(req.op) == IORSD_OP_DATA_READ || iorsd_op_type'(req.op) == IORSD_OP_DATA_WRITE)
                   && req.addr >= EXT_FIRST && req.addr <= EXT_LAST; // R8
  assign bit_mask = onehot(req.bit_sel);

  // A bit operation writes the current value with only the target bit changed;
  // for a bit set the w1c vector carries only that bit and for a bit clear it stays zero, so other pending flags survive.
  always_comb begin
    wval = req.wdata;
    w1c = 8'h00;
    if (wr_acc) begin
      w1c = req.wdata; // R3
    end else if (bit_acc && iorsd_op_type'(req.op) == IORSD_OP_SET_BIT) begin
      wval = cur | bit_mask; // R4
      w1c = bit_mask; // R4
    end else if (bit_acc && iorsd_op_type'(req.op) == IORSD_OP_CLEAR_BIT) begin
      wval = cur & ~bit_mask; // R4
    end
  end

  logic do_wr;
  assign do_wr = wr_acc || (bit_acc && (iorsd_op_type'(req.op) == IORSD_OP_SET_BIT
                 || iorsd_op_type'(req.op) == IORSD_OP_CLEAR_BIT)); // R1

  // All registers share one write strobe and the location compare picks the target.
  // One access therefore changes at most one location; at the comparator control that is cmp_r and its flag.
  function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
    hit = do_wr && (a == o);
  endfunction

  // ----------------------------------------------------------------
  // Plain read/write storage
  // ----------------------------------------------------------------
  logic [7:0] nvm_ctl_r;
  logic [7:0] nvm_data_r;
  logic [7:0] nvm_al_r;
  logic [7:0] nvm_ah_r;
  logic [7:0] presc_r;
  logic [7:0] t0a_r;
  logic [7:0] t0b_r;
  logic [7:0] t0cnt_r;
  logic [7:0] t0ca_r;
  logic [7:0] t0cb_r;
  logic [7:0] scr0_r;
  logic [7:0] scr1_r;
  logic [7:0] scr2_r;
  logic [7:0] spctl_r;
  logic [7:0] spflg_r;
  logic [7:0] spdat_r;
  logic [7:0] cmp_r;
  logic [7:0] external_irq_mask_r;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      port_b_dir <= REG_RESET;
      port_b_out <= REG_RESET;
      port_c_dir <= REG_RESET;
      port_c_out <= REG_RESET;
      port_d_dir <= REG_RESET;
      port_d_out <= REG_RESET;
    end else begin
      if (hit(loc, OFS_PORT_B_DIRECTION)) port_b_dir <= wval;
      if (hit(loc, OFS_PORT_B_OUTPUT_LATCH)) port_b_out <= wval;
      if (hit(loc, OFS_PORT_C_DIRECTION)) port_c_dir <= wval & MASK_PORT_C; // R9
      if (hit(loc, OFS_PORT_C_OUTPUT_LATCH)) port_c_out <= wval & MASK_PORT_C; // R9
      if (hit(loc, OFS_PORT_D_DIRECTION)) port_d_dir <= wval;
      if (hit(loc, OFS_PORT_D_OUTPUT_LATCH)) port_d_out <= wval;
      // Writing one to a pin-level location toggles the output latch.
      if (hit(loc, OFS_PORT_B_PIN_LEVEL)) port_b_out <= port_b_out ^ w1c;
      if (hit(loc, OFS_PORT_C_PIN_LEVEL)) port_c_out <= (port_c_out ^ w1c) & MASK_PORT_C;
      if (hit(loc, OFS_PORT_D_PIN_LEVEL)) port_d_out <= port_d_out ^ w1c;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      nvm_ctl_r <= REG_RESET;
      nvm_data_r <= REG_RESET;
      nvm_al_r <= REG_RESET;
      nvm_ah_r <= REG_RESET;
      presc_r <= REG_RESET;
      t0a_r <= REG_RESET;
      t0b_r <= REG_RESET;
      t0cnt_r <= REG_RESET;
      t0ca_r <= REG_RESET;
      t0cb_r <= REG_RESET;
      scr0_r <= REG_RESET;
      scr1_r <= REG_RESET;
      scr2_r <= REG_RESET;
      spctl_r <= REG_RESET;
      spdat_r <= REG_RESET;
      external_irq_mask_r <= REG_RESET;
    end else begin
      if (hit(loc, OFS_NVM_CONTROL)) nvm_ctl_r <= wval & MASK_NVM_CONTROL; // R9
      if (hit(loc, OFS_NVM_DATA)) nvm_data_r <= wval;
      if (hit(loc, OFS_NVM_ADDRESS_LOW)) nvm_al_r <= wval;
      if (hit(loc, OFS_NVM_ADDRESS_HIGH)) nvm_ah_r <= wval & MASK_NVM_ADDRESS_HIGH; // R9
      if (hit(loc, OFS_PRESCALER_SYNC_CONTROL)) presc_r <= wval & MASK_PRESCALER_SYNC; // R9
      if (hit(loc, OFS_TIMER0_CONTROL_A)) t0a_r <= wval & MASK_TIMER0_CONTROL_A; // R9
      if (hit(loc, OFS_TIMER0_CONTROL_B)) t0b_r <= wval & MASK_TIMER0_CONTROL_B; // R9
      if (hit(loc, OFS_TIMER0_COUNT)) t0cnt_r <= wval;
      if (hit(loc, OFS_TIMER0_COMPARE_A)) t0ca_r <= wval;
      if (hit(loc, OFS_TIMER0_COMPARE_B)) t0cb_r <= wval;
      if (hit(loc, OFS_SCRATCH_REG_0)) scr0_r <= wval;
      if (hit(loc, OFS_SCRATCH_REG_1)) scr1_r <= wval;
      if (hit(loc, OFS_SCRATCH_REG_2)) scr2_r <= wval;
      if (hit(loc, OFS_SERIAL_PERIPH_CONTROL)) spctl_r <= wval;
      if (hit(loc, OFS_SERIAL_PERIPH_DATA)) spdat_r <= wval;
      if (hit(loc, OFS_EXTERNAL_IRQ_MASK)) external_irq_mask_r <= wval & MASK_EXT_IRQ; // R9
    end
  end

  // ----------------------------------------------------------------
  // Status flags: a set in the same cycle as its clear wins
  // ----------------------------------------------------------------
  function automatic logic [7:0] flag_nxt(input logic [7:0] q, input logic [7:0] set,
                                          input logic [7:0] clr, input logic [7:0] mask);
    flag_nxt = ((q & ~clr) | set) & mask; // R3
  endfunction

  function automatic logic [7:0] clr_for(input logic [5:0] o);
    clr_for = hit(loc, o) ? w1c : 8'h00; // R3
  endfunction

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      flag_q <= '0;
      spflg_r <= REG_RESET;
      cmp_r <= REG_RESET;
    end else begin
      flag_q.timer0 <= flag_nxt(flag_q.timer0, flag_set.timer0, clr_for(OFS_TIMER0_FLAGS), MASK_TIMER_FLAGS);
      flag_q.timer1 <= flag_nxt(flag_q.timer1, flag_set.timer1, clr_for(OFS_TIMER1_FLAGS), MASK_TIMER1_FLAGS);
      flag_q.timer2 <= flag_nxt(flag_q.timer2, flag_set.timer2, clr_for(OFS_TIMER2_FLAGS), MASK_TIMER_FLAGS);
      flag_q.pin_change <= flag_nxt(flag_q.pin_change, flag_set.pin_change, clr_for(OFS_PIN_CHANGE_FLAGS),
                                    MASK_PIN_CHANGE_FLAGS);
      flag_q.ext_irq <= flag_nxt(flag_q.ext_irq, flag_set.ext_irq, clr_for(OFS_EXTERNAL_IRQ_FLAGS), MASK_EXT_IRQ);
      // Serial flags get no clear vector and drop only at reset, so no core write reaches them.
      flag_q.serial <= flag_nxt(flag_q.serial, flag_set.serial, 8'h00, MASK_SERIAL_FLAGS_RO);
      flag_q.comparator <= flag_nxt(flag_q.comparator, flag_set.comparator,
                                    clr_for(OFS_COMPARATOR_CONTROL), MASK_COMPARATOR_W1C); // R3
      if (hit(loc, OFS_SERIAL_PERIPH_FLAGS)) spflg_r <= wval & MASK_SERIAL_FLAGS_RW; // R9
      if (hit(loc, OFS_COMPARATOR_CONTROL)) cmp_r <= wval & MASK_COMPARATOR_RW & ~MASK_COMPARATOR_W1C;
    end
  end

  // ----------------------------------------------------------------
  // Pin sampling: three stages, a change counts when two and three agree
  // ----------------------------------------------------------------
  logic [7:0] pb_s1_r, pb_s2_r, pb_s3_r, pb_r;
  logic [7:0] pc_s1_r, pc_s2_r, pc_s3_r, pc_r;
  logic [7:0] pd_s1_r, pd_s2_r, pd_s3_r, pd_r;

  // A bit keeps its old value while stages two and three disagree.
  // A pin that moves during sampling is then taken a cycle late, never as a half-settled level.
  function automatic logic [7:0] settle(input logic [7:0] q, input logic [7:0] s2, input logic [7:0] s3);
    settle = ((s2 ~^ s3) & s2) | ((s2 ^ s3) & q);
  endfunction

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      {pb_s1_r, pb_s2_r, pb_s3_r, pb_r} <= '0;
      {pc_s1_r, pc_s2_r, pc_s3_r, pc_r} <= '0;
      {pd_s1_r, pd_s2_r, pd_s3_r, pd_r} <= '0;
    end else begin
      {pb_s3_r, pb_s2_r, pb_s1_r} <= {pb_s2_r, pb_s1_r, port_b_pins};
      {pc_s3_r, pc_s2_r, pc_s1_r} <= {pc_s2_r, pc_s1_r, port_c_pins & MASK_PORT_C};
      {pd_s3_r, pd_s2_r, pd_s1_r} <= {pd_s2_r, pd_s1_r, port_d_pins};
      pb_r <= settle(pb_r, pb_s2_r, pb_s3_r);
      pc_r <= settle(pc_r, pc_s2_r, pc_s3_r);
      pd_r <= settle(pd_r, pd_s2_r, pd_s3_r);
    end
  end

  // ----------------------------------------------------------------
  // Read mux and answer
  // ----------------------------------------------------------------
  // Holes in the map fall to the default and read zero, so a read never shows stale data.
  always_comb begin
    case (loc)
      OFS_PORT_B_PIN_LEVEL: cur = pb_r;
      OFS_PORT_B_DIRECTION: cur = port_b_dir;
      OFS_PORT_B_OUTPUT_LATCH: cur = port_b_out;
      OFS_PORT_C_PIN_LEVEL: cur = pc_r;
      OFS_PORT_C_DIRECTION: cur = port_c_dir;
      OFS_PORT_C_OUTPUT_LATCH: cur = port_c_out;
      OFS_PORT_D_PIN_LEVEL: cur = pd_r;
      OFS_PORT_D_DIRECTION: cur = port_d_dir;
      OFS_PORT_D_OUTPUT_LATCH: cur = port_d_out;
      OFS_TIMER0_FLAGS: cur = flag_q.timer0;
      OFS_TIMER1_FLAGS: cur = flag_q.timer1;
      OFS_TIMER2_FLAGS: cur = flag_q.timer2;
      OFS_PIN_CHANGE_FLAGS: cur = flag_q.pin_change;
      OFS_EXTERNAL_IRQ_FLAGS: cur = flag_q.ext_irq;
      OFS_EXTERNAL_IRQ_MASK: cur = external_irq_mask_r;
      OFS_SCRATCH_REG_0: cur = scr0_r;
      OFS_NVM_CONTROL: cur = nvm_ctl_r;
      OFS_NVM_DATA: cur = nvm_data_r;
      OFS_NVM_ADDRESS_LOW: cur = nvm_al_r;
      OFS_NVM_ADDRESS_HIGH: cur = nvm_ah_r;
      OFS_PRESCALER_SYNC_CONTROL: cur = presc_r;
      OFS_TIMER0_CONTROL_A: cur = t0a_r;
      OFS_TIMER0_CONTROL_B: cur = t0b_r;
      OFS_TIMER0_COUNT: cur = t0cnt_r;
      OFS_TIMER0_COMPARE_A: cur = t0ca_r;
      OFS_TIMER0_COMPARE_B: cur = t0cb_r;
      OFS_SCRATCH_REG_1: cur = scr1_r;
      OFS_SCRATCH_REG_2: cur = scr2_r;
      OFS_SERIAL_PERIPH_CONTROL: cur = spctl_r;
      OFS_SERIAL_PERIPH_FLAGS: cur = flag_q.serial | spflg_r;
      OFS_SERIAL_PERIPH_DATA: cur = spdat_r;
      OFS_COMPARATOR_CONTROL: cur = cmp_r | flag_q.comparator;
      default: cur = 8'h00; // R9
    endcase
  end

  // Answers are registered so the core sees data one cycle after the request.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rsp <= '0;
    end else begin
      rsp.hit <= rd_acc || ext_sel;
      rsp.rdata <= ext_sel ? ext_rdata : (rd_acc ? cur : 8'h00); // R8
      rsp.skip <= bit_acc && ((iorsd_op_type'(req.op) == IORSD_OP_SKIP_IF_ONE && cur[req.bit_sel])
                  || (iorsd_op_type'(req.op) == IORSD_OP_SKIP_IF_ZERO && !cur[req.bit_sel])); // R2
    end
  end

endmodule

//--- hw/iorsd_pkg.sv
package iorsd_pkg;

  // ----------------------------------------------------------------
  // Address spaces
  // ----------------------------------------------------------------
  localparam logic [7:0] IO_DATA_OFFSET = 8'h20;
  localparam logic [7:0] IO_LAST = 8'h3f;
  localparam logic [7:0] IO_BIT_LAST = 8'h1f;
  localparam logic [7:0] EXT_FIRST = 8'h60;
  localparam logic [7:0] EXT_LAST = 8'hff;

  // ----------------------------------------------------------------
  // Register offsets (I/O space)
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_PORT_B_PIN_LEVEL = 6'h03;
  localparam logic [5:0] OFS_PORT_B_DIRECTION = 6'h04;
  localparam logic [5:0] OFS_PORT_B_OUTPUT_LATCH = 6'h05;
  localparam logic [5:0] OFS_PORT_C_PIN_LEVEL = 6'h06;
  localparam logic [5:0] OFS_PORT_C_DIRECTION = 6'h07;
  localparam logic [5:0] OFS_PORT_C_OUTPUT_LATCH = 6'h08;
  localparam logic [5:0] OFS_PORT_D_PIN_LEVEL = 6'h09;
  localparam logic [5:0] OFS_PORT_D_DIRECTION = 6'h0a;
  localparam logic [5:0] OFS_PORT_D_OUTPUT_LATCH = 6'h0b;
  localparam logic [5:0] OFS_TIMER0_FLAGS = 6'h15;
  localparam logic [5:0] OFS_TIMER1_FLAGS = 6'h16;
  localparam logic [5:0] OFS_TIMER2_FLAGS = 6'h17;
  localparam logic [5:0] OFS_PIN_CHANGE_FLAGS = 6'h1b;
  localparam logic [5:0] OFS_EXTERNAL_IRQ_FLAGS = 6'h1c;
  localparam logic [5:0] OFS_EXTERNAL_IRQ_MASK = 6'h1d;
  localparam logic [5:0] OFS_SCRATCH_REG_0 = 6'h1e;
  localparam logic [5:0] OFS_NVM_CONTROL = 6'h1f;
  localparam logic [5:0] OFS_NVM_DATA = 6'h20;
  localparam logic [5:0] OFS_NVM_ADDRESS_LOW = 6'h21;
  localparam logic [5:0] OFS_NVM_ADDRESS_HIGH = 6'h22;
  localparam logic [5:0] OFS_PRESCALER_SYNC_CONTROL = 6'h23;
  localparam logic [5:0] OFS_TIMER0_CONTROL_A = 6'h24;
  localparam logic [5:0] OFS_TIMER0_CONTROL_B = 6'h25;
  localparam logic [5:0] OFS_TIMER0_COUNT = 6'h26;
  localparam logic [5:0] OFS_TIMER0_COMPARE_A = 6'h27;
  localparam logic [5:0] OFS_TIMER0_COMPARE_B = 6'h28;
  localparam logic [5:0] OFS_SCRATCH_REG_1 = 6'h2a;
  localparam logic [5:0] OFS_SCRATCH_REG_2 = 6'h2b;
  localparam logic [5:0] OFS_SERIAL_PERIPH_CONTROL = 6'h2c;
  localparam logic [5:0] OFS_SERIAL_PERIPH_FLAGS = 6'h2d;
  localparam logic [5:0] OFS_SERIAL_PERIPH_DATA = 6'h2e;
  localparam logic [5:0] OFS_COMPARATOR_CONTROL = 6'h30;

  // ----------------------------------------------------------------
  // Implemented-bit masks and reset value
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_PORT_C = 8'h7f;
  localparam logic [7:0] MASK_TIMER_FLAGS = 8'h07;
  localparam logic [7:0] MASK_TIMER1_FLAGS = 8'h27;
  localparam logic [7:0] MASK_PIN_CHANGE_FLAGS = 8'h07;
  localparam logic [7:0] MASK_EXT_IRQ = 8'h03;
  localparam logic [7:0] MASK_NVM_CONTROL = 8'h3f;
  localparam logic [7:0] MASK_NVM_ADDRESS_HIGH = 8'h01;
  localparam logic [7:0] MASK_PRESCALER_SYNC = 8'h83;
  localparam logic [7:0] MASK_TIMER0_CONTROL_A = 8'hf3;
  localparam logic [7:0] MASK_TIMER0_CONTROL_B = 8'hcf;
  localparam logic [7:0] MASK_SERIAL_FLAGS_RW = 8'h01;
  localparam logic [7:0] MASK_SERIAL_FLAGS_RO = 8'hc0;
  localparam logic [7:0] MASK_COMPARATOR_RW = 8'hdf;
  localparam logic [7:0] MASK_COMPARATOR_W1C = 8'h10;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Core request and answer
  // ----------------------------------------------------------------
  typedef enum {
    IORSD_OP_NONE,
    IORSD_OP_IO_READ,
    IORSD_OP_IO_WRITE,
    IORSD_OP_DATA_READ,
    IORSD_OP_DATA_WRITE,
    IORSD_OP_SET_BIT,
    IORSD_OP_CLEAR_BIT,
    IORSD_OP_SKIP_IF_ONE,
    IORSD_OP_SKIP_IF_ZERO
  } iorsd_op_type;

  typedef struct packed {
    logic [3:0] op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } iorsd_req_type;

  typedef struct packed {
    logic [7:0] rdata;
    logic skip;
    logic hit;
  } iorsd_rsp_type;

  typedef struct packed {
    logic [7:0] timer0;
    logic [7:0] timer1;
    logic [7:0] timer2;
    logic [7:0] pin_change;
    logic [7:0] ext_irq;
    logic [7:0] serial;
    logic [7:0] comparator;
  } iorsd_flags_type;

endpackage

//--- bench/iorsd_decoder_chk.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port-level checker for the I/O register decoder
// ----------------------------------------------------------------
module iorsd_decoder_chk
  import iorsd_pkg::*;
(
  input wire logic core_clk, // System clock.
  input wire logic rst_b, // Synchronous reset, active low.
  input wire iorsd_req_type req, // Access from the core.
  input wire iorsd_rsp_type rsp, // Registered answer.
  input wire logic ext_sel, // Extended space selected.
  input wire logic [7:0] ext_rdata, // Extended space read data.
  input wire iorsd_flags_type flag_set, // Flag set pulses.
  input wire iorsd_flags_type flag_q, // Status flags.
  input wire logic [7:0] port_b_out // Port B output latch.
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // The answer lags its request by one edge, so the request is kept one cycle to pair them.
  iorsd_req_type q_r;
  iorsd_flags_type set_r;
  iorsd_flags_type flg_r;
  logic [7:0] ext_r;
  logic [7:0] pb_r;

  always_ff @(posedge core_clk) begin
    q_r <= req;
    set_r <= flag_set;
    flg_r <= flag_q;
    ext_r <= ext_rdata;
    pb_r <= port_b_out;
  end

  ext_decode_a: assert property (ext_sel == (req.op inside {4'd3, 4'd4} && req.addr >= EXT_FIRST))
    else $error("extended select does not follow the data address");
  ext_read_a: assert property (q_r.op == 4'd3 && q_r.addr >= EXT_FIRST |-> rsp.hit && rsp.rdata == ext_r)
    else $error("extended read did not return extended data");
  bit_range_a: assert property (req.op inside {[4'd5:4'd8]} && req.addr > IO_BIT_LAST |=> rsp == '0)
    else $error("bit operation above the bit range was answered");
  io_range_a: assert property (req.op inside {4'd1, 4'd2} && req.addr > IO_LAST |=> rsp == '0)
    else $error("io access above the io range was answered");
  data_low_a: assert property (req.op inside {4'd3, 4'd4} && req.addr < IO_DATA_OFFSET |=> rsp == '0)
    else $error("data access below the io window was answered");
  w1c_write_a: assert property (q_r.op == 4'd2 && q_r.addr == 8'h15 && set_r.timer0 == 8'h00
    |-> flag_q.timer0 == (flg_r.timer0 & ~q_r.wdata))
    else $error("flag write did not clear exactly the ones written");
  set_bit_a: assert property (q_r.op == 4'd5 && q_r.addr == 8'h15 && set_r.timer0 == 8'h00
    |-> flag_q.timer0 == (flg_r.timer0 & ~(8'h01 << q_r.bit_sel)))
    else $error("bit set on flags touched other bits");
  clr_keep_a: assert property (req.op == 4'd6 && req.addr == 8'h1c && flag_set.ext_irq == 8'h00
    |=> $stable(flag_q.ext_irq))
    else $error("bit clear changed pending flags");
  skip_bit_a: assert property (q_r.op == 4'd7 && q_r.addr == 8'h05 |-> rsp.skip == pb_r[q_r.bit_sel])
    else $error("skip result differs from the selected bit");
  alias_write_a: assert property (q_r.op == 4'd4 && q_r.addr == 8'h25 |-> port_b_out == q_r.wdata)
    else $error("data store did not reach the aliased latch");
endmodule

bind iorsd_decoder iorsd_decoder_chk iorsd_decoder_chk_inst (.core_clk, .rst_b, .req, .rsp, .ext_sel,
  .ext_rdata, .flag_set, .flag_q, .port_b_out);

//--- bench/iorsd_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Core side: issues accesses and serves the extended space
// ----------------------------------------------------------------
module iorsd_core_model
  import iorsd_pkg::*;
(
  input wire logic core_clk, // System clock.
  output iorsd_req_type req, // Access to the decoder.
  input wire iorsd_rsp_type rsp, // Answer from the decoder.
  input wire logic ext_sel, // Extended space selected.
  output logic [7:0] ext_rdata // Extended space read data.
);
  logic [7:0] cyc_r = 8'h00;

  initial req = '0;

  always @(posedge core_clk) cyc_r <= cyc_r + 8'h01;

  // Unselected, the bus shows a moving pattern so stale data can never pass for a match.
  assign ext_rdata = ext_sel ? (req.addr ^ 8'h5a) : cyc_r;

  // One access then an idle cycle; the answer is taken just after the edge that registers it.
  task automatic issue(input logic [3:0] op, input logic [7:0] a, input logic [2:0] b,
                       input logic [7:0] w, output iorsd_rsp_type r);
    @(posedge core_clk);
    req <= {op, a, b, w};
    @(posedge core_clk);
    req <= '0;
    #1;
    r = rsp;
  endtask
endmodule

//--- bench/iorsd_decoder_test.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench for the I/O register decoder
// ----------------------------------------------------------------
module iorsd_decoder_test;
  import iorsd_pkg::*;
  logic core_clk;
  logic rst_b;
  iorsd_req_type req;
  iorsd_rsp_type rsp;
  iorsd_rsp_type r;
  logic ext_sel;
  logic [7:0] ext_rdata;
  iorsd_flags_type flag_set;
  iorsd_flags_type flag_q;
  logic [7:0] port_b_pins, port_c_pins, port_d_pins;
  logic [7:0] port_b_dir, port_b_out, port_c_dir, port_c_out, port_d_dir, port_d_out;
  logic [7:0] v, w;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  localparam logic [5:0] OFS_T [10] = '{6'h04, 6'h07, 6'h0a, 6'h1d, 6'h1e, 6'h21, 6'h22, 6'h24, 6'h2b, 6'h2c};
  localparam logic [7:0] MSK_T [10] = '{8'hff, 8'h7f, 8'hff, 8'h03, 8'hff, 8'hff, 8'h01, 8'hf3, 8'hff, 8'hff};
  localparam logic [7:0] RSV_T [7] = '{8'h00, 8'h0c, 8'h10, 8'h1a, 8'h29, 8'h2f, 8'h31};

  iorsd_decoder iorsd_decoder_inst (.core_clk, .rst_b, .req, .rsp, .ext_sel, .ext_rdata, .flag_set, .flag_q,
    .port_b_pins, .port_c_pins, .port_d_pins, .port_b_dir, .port_b_out, .port_c_dir, .port_c_out,
    .port_d_dir, .port_d_out);
  iorsd_core_model iorsd_core_model_inst (.core_clk, .req, .rsp, .ext_sel, .ext_rdata);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  function automatic logic [7:0] bitv(input logic [2:0] b);
    return 8'h01 << b;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic acc(input logic [3:0] op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] wd);
    iorsd_core_model_inst.issue(op, a, b, wd, r);
  endtask

  task automatic pulse(input iorsd_flags_type f);
    @(posedge core_clk);
    flag_set <= f;
    @(posedge core_clk);
    flag_set <= '0;
  endtask

  task automatic end_sim;
    if (n_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      end_sim();
    end
  end

  initial begin
    rst_b = 1'b0;
    flag_set = '0;
    port_b_pins = 8'h00;
    port_c_pins = 8'h00;
    port_d_pins = 8'h00;
    void'($urandom(32'hbe5ceb72));
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 64; a++) begin
      acc(4'd1, 8'(a), 3'd0, 8'h00);
      check(r.rdata, 8'h00, "reset value");
    end
    for (int i = 0; i < 10; i++) begin
      w = 8'($urandom);
      acc(4'd2, {2'b00, OFS_T[i]}, 3'd0, w);
      acc(4'd3, {2'b00, OFS_T[i]} + IO_DATA_OFFSET, 3'd0, 8'h00);
      check(r.rdata, w & MSK_T[i], "io write then data read");
      acc(4'd4, {2'b00, OFS_T[i]} + IO_DATA_OFFSET, 3'd0, ~w);
      acc(4'd1, {2'b00, OFS_T[i]}, 3'd0, 8'h00);
      check(r.rdata, ~w & MSK_T[i], "data write then io read");
    end
    for (int i = 0; i < 7; i++) begin
      acc(4'd2, RSV_T[i], 3'd0, 8'hff);
      acc(4'd1, RSV_T[i], 3'd0, 8'h00);
      check(r.rdata, 8'h00, "reserved location");
    end
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      acc(4'd2, 8'h05, 3'd0, v);
      acc(4'd5, 8'h05, 3'(i), 8'h00);
      check(port_b_out, v | bitv(3'(i)), "bit set");
      acc(4'd7, 8'h05, 3'(i), 8'h00);
      check(8'(r.skip), 8'h01, "skip if one");
      acc(4'd6, 8'h05, 3'(i), 8'h00);
      check(port_b_out, v & ~bitv(3'(i)), "bit clear");
      acc(4'd8, 8'h05, 3'(i), 8'h00);
      check(8'(r.skip), 8'h01, "skip if zero");
    end
    acc(4'd2, 8'h2a, 3'd0, 8'h3c);
    acc(4'd5, 8'h2a, 3'd0, 8'h00);
    check(8'(r.hit), 8'h00, "bit set above range");
    acc(4'd6, 8'h2a, 3'd2, 8'h00);
    acc(4'd8, 8'h2a, 3'd0, 8'h00);
    check(8'(r.skip), 8'h00, "skip above range");
    acc(4'd1, 8'h2a, 3'd0, 8'h00);
    check(r.rdata, 8'h3c, "bit ops above range");
    acc(4'd1, 8'h7e, 3'd0, 8'h00);
    check(8'(r.hit), 8'h00, "io read above range");
    v = port_d_dir;
    acc(4'd2, 8'h4a, 3'd0, ~v);
    check(port_d_dir, v, "io write above range");
    v = port_b_out;
    acc(4'd4, 8'h05, 3'd0, ~v);
    check(port_b_out, v, "data store below window");
    acc(4'd3, 8'ha7, 3'd0, 8'h00);
    check(r.rdata, 8'ha7 ^ 8'h5a, "extended read");
    acc(4'd4, 8'hff, 3'd0, 8'h11);
    check(8'(r.hit), 8'h01, "extended write");
    acc(4'd5, 8'h60, 3'd0, 8'h00);
    check(8'(r.hit), 8'h00, "bit op on extended");
    pulse('{timer0: 8'h07, timer1: 8'h27, ext_irq: 8'h03, default: 8'h00});
    acc(4'd2, 8'h15, 3'd0, 8'h02);
    check(flag_q.timer0, 8'h05, "write one clears");
    acc(4'd2, 8'h15, 3'd0, 8'h00);
    check(flag_q.timer0, 8'h05, "write zero keeps");
    acc(4'd5, 8'h15, 3'd0, 8'h00);
    check(flag_q.timer0, 8'h04, "bit set on flags");
    acc(4'd6, 8'h1c, 3'd1, 8'h00);
    check(flag_q.ext_irq, 8'h03, "bit clear on flags");
    acc(4'd7, 8'h15, 3'd2, 8'h00);
    check(8'(r.skip), 8'h01, "skip on flag");
    acc(4'd4, 8'h3c, 3'd0, 8'h01);
    check(flag_q.ext_irq, 8'h02, "flag clear by store");
    acc(4'd3, 8'h36, 3'd0, 8'h00);
    check(r.rdata, 8'h27, "flag read by load");
    pulse('{serial: 8'hff, comparator: 8'hff, timer2: 8'hff, pin_change: 8'hff, default: 8'h00});
    acc(4'd2, 8'h2d, 3'd0, 8'hff);
    acc(4'd1, 8'h2d, 3'd0, 8'h00);
    check(r.rdata, 8'hc1, "serial flags stay");
    acc(4'd2, 8'h30, 3'd0, 8'hff);
    acc(4'd1, 8'h30, 3'd0, 8'h00);
    check(r.rdata, 8'hcf, "comparator flag clears");
    acc(4'd5, 8'h1b, 3'd1, 8'h00);
    acc(4'd3, 8'h3b, 3'd0, 8'h00);
    check(r.rdata, 8'h05, "bit set on change flags");
    acc(4'd1, 8'h17, 3'd0, 8'h00);
    check(r.rdata, 8'h07, "unused timer flag bits");
    v = 8'($urandom);
    w = 8'($urandom);
    @(posedge core_clk);
    port_d_pins <= v;
    port_c_pins <= w;
    port_b_pins <= 8'hff;
    repeat (5) @(posedge core_clk);
    acc(4'd3, 8'h29, 3'd0, 8'h00);
    check(r.rdata, v, "pin level by load");
    acc(4'd1, 8'h06, 3'd0, 8'h00);
    check(r.rdata, w & 8'h7f, "unimplemented pin bit");
    @(posedge core_clk);
    port_b_pins <= v;
    repeat (5) @(posedge core_clk);
    acc(4'd3, 8'h23, 3'd0, 8'h00);
    check(r.rdata, v, "pin level falls");
    v = port_b_out;
    w = 8'($urandom);
    acc(4'd2, 8'h03, 3'd0, w);
    check(port_b_out, v ^ w, "pin write toggles latch");
    acc(4'd2, 8'h1e, 3'd0, 8'ha5);
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    acc(4'd1, 8'h1e, 3'd0, 8'h00);
    check(r.rdata, 8'h00, "value after second reset");
    check(port_b_out, 8'h00, "latch after second reset");
    end_sim();
  end
endmodule
